// File: rtl/sie_irq_ctrl.sv
// Interrupt enable set/clear, flags and request line behind Avalon-MM
`timescale 1ns/1ps
module sie_irq_ctrl
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire sie_pkg::sie_avs_req_type avs,
  output sie_pkg::sie_avs_rsp_type avsRsp,
  input  wire logic                writeProtect,
  input  wire logic [11:0]         statusPin,
  output logic                     irq
);
  import sie_pkg::*;

  sie_src_type enable;
  sie_src_type flag;
  sie_src_type statusSync;
  sie_src_type statusRise;
  logic        waitReq;
  logic [31:0] readData;
  logic [31:0] next_readData;
  logic [11:0] wrBits;
  logic        wrAccept;
  logic        setWr;
  logic        clrWr;
  logic        flagWr;
  logic        rdStart;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [11:0] laneMask(input logic [3:0] be);
    return {{4{be[1]}}, {8{be[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Status synchroniser and edge detector
  sie_rise_detect uRise
  (
    .clk        (clk),
    .rst        (rst),
    .statusPin  (statusPin),
    .statusSync (statusSync),
    .statusRise (statusRise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign wrAccept = avs.write && !waitReq;
  assign rdStart  = avs.read && waitReq;
  assign wrBits   = avs.writedata[11:0] & laneMask(avs.byteenable);
  assign setWr    = wrAccept && !writeProtect
                    && hit(avs.address, OFS_ENABLE_SET); // RULE1
  assign clrWr    = wrAccept && !writeProtect
                    && hit(avs.address, OFS_ENABLE_CLEAR);
  assign flagWr   = wrAccept && hit(avs.address, OFS_FLAG);

  ////////////////////////////////////////////////////////////////////////
  // Waitrequest: one wait cycle, then one accept cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      waitReq <= 1'b1;
    else if (!waitReq)
      waitReq <= 1'b1;
    else if (avs.read || avs.write)
      waitReq <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, captured in the wait cycle
  always_comb
  begin
    next_readData = readData;
    if (rdStart)
    begin
      if (hit(avs.address, OFS_ENABLE_SET) ||
          hit(avs.address, OFS_ENABLE_CLEAR))
        next_readData = {RESERVED_READ, enable}; // RULE5
      else if (hit(avs.address, OFS_FLAG))
        next_readData = {RESERVED_READ, flag};
      else if (hit(avs.address, OFS_STATUS))
        next_readData = {RESERVED_READ, statusSync};
      else
        next_readData = 32'h00000000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      readData <= 32'h00000000;
    else
      readData <= next_readData;
  end

  assign avsRsp = '{readdata: readData, waitrequest: waitReq};

  ////////////////////////////////////////////////////////////////////////
  // Enable bits: write one to set, write one to clear
  always_ff @(posedge clk)
  begin
    if (rst)
      enable <= ENABLE_RESET; // RULE1
    else if (setWr)
      enable <= enable | wrBits; // RULE2 RULE3
    else if (clrWr)
      enable <= enable & ~wrBits; // RULE9
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: set by status edge, which wins over a clear
  always_ff @(posedge clk)
  begin
    if (rst)
      flag <= FLAG_RESET;
    else if (flagWr)
      flag <= (flag & ~wrBits) | statusRise; // RULE10 RULE11
    else
      flag <= flag | statusRise; // RULE10
  end

  ////////////////////////////////////////////////////////////////////////
  // Combined request line
  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(enable & flag); // RULE4 RULE12
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_reset_disables: assert property ( // RULE1
    @(posedge clk) $fell(rst) |-> (enable == 12'h000 && !irq))
    else $error("enable not cleared by reset");

  a_zero_keeps: assert property ( // RULE2
    @(posedge clk) disable iff (rst)
    setWr |=> (enable & ~$past(wrBits)) == ($past(enable) & ~$past(wrBits)))
    else $error("zero written to set register changed an enable");

  a_one_sets: assert property ( // RULE3
    @(posedge clk) disable iff (rst)
    setWr |=> (enable & $past(wrBits)) == $past(wrBits))
    else $error("one written to set register did not enable");

  a_clear_disables: assert property ( // RULE9
    @(posedge clk) disable iff (rst)
    clrWr |=> ((enable & $past(wrBits)) == 12'h000)
      && ((enable & ~$past(wrBits)) == ($past(enable) & ~$past(wrBits))))
    else $error("clear register write misbehaved");

  a_irq_raised: assert property ( // RULE4 RULE12
    @(posedge clk) disable iff (rst)
    (|(enable & flag)) |=> irq)
    else $error("irq missing for enabled flagged source");

  a_irq_gated: assert property ( // RULE4
    @(posedge clk) disable iff (rst)
    !(|(enable & flag)) |=> !irq)
    else $error("irq raised without enabled flagged source");

  a_read_enable: assert property ( // RULE5
    @(posedge clk) disable iff (rst)
    (rdStart && hit(avs.address, OFS_ENABLE_SET))
      |=> !waitReq && readData == {20'h00000, $past(enable)})
    else $error("enable read back wrong");

  a_flag_sets: assert property ( // RULE10
    @(posedge clk) disable iff (rst)
    (|statusRise) |=> (flag & $past(statusRise)) == $past(statusRise))
    else $error("status edge did not set flag");

  a_flag_clears: assert property ( // RULE11
    @(posedge clk) disable iff (rst)
    flagWr |=> (flag & $past(wrBits & ~statusRise)) == 12'h000
      && (flag & ~$past(wrBits)) == ($past(flag | statusRise)
      & ~$past(wrBits)))
    else $error("flag write one-to-clear misbehaved");

  a_bus_answer: assert property (
    @(posedge clk) disable iff (rst)
    ((avs.read || avs.write) && waitReq) |=> !waitReq ##1 waitReq)
    else $error("waitrequest sequence wrong");

  a_bus_idle: assert property (
    @(posedge clk) disable iff (rst)
    (!(avs.read || avs.write) && waitReq) |=> waitReq)
    else $error("waitrequest dropped without request");

  a_protect_holds: assert property ( // RULE1
    @(posedge clk) disable iff (rst)
    (wrAccept && writeProtect) |=> enable == $past(enable))
    else $error("protected write changed an enable");

  a_reset_irq_low: assert property ( // RULE1
    @(posedge clk) rst |=> (!irq && enable == ENABLE_RESET && waitReq
      && readData == 32'h00000000))
    else $error("reset left irq, enables or bus state set");

  a_read_alias: assert property ( // RULE9
    @(posedge clk) disable iff (rst)
    (rdStart && hit(avs.address, OFS_ENABLE_CLEAR))
      |=> readData == {RESERVED_READ, $past(enable)})
    else $error("clear register read back wrong");

  a_read_flag: assert property ( // RULE10
    @(posedge clk) disable iff (rst)
    (rdStart && hit(avs.address, OFS_FLAG))
      |=> readData == {RESERVED_READ, $past(flag)})
    else $error("flag read back wrong");

  a_read_status: assert property ( // RULE10
    @(posedge clk) disable iff (rst)
    (rdStart && hit(avs.address, OFS_STATUS))
      |=> readData == {RESERVED_READ, $past(statusSync)})
    else $error("status read back wrong");

  a_flag_edge_only: assert property ( // RULE10
    @(posedge clk) disable iff (rst)
    !flagWr |=> (flag & ~$past(flag)) == $past(statusRise & ~flag))
    else $error("flag set without status edge");

endmodule

// File: rtl/sie_pkg.sv
// Package: register map, reset values and bus types of the interrupt enable block
// Summary of operation
// RULE1 - Enable-set register at 0x04, resets zero, protected
// RULE2 - Writing zero to enable bit changes nothing
// RULE3 - Writing one to enable bit enables source
// RULE4 - Request raised only when enable and flag set
// RULE5 - Reading enable bit returns its current state
// RULE6 - Supply-monitor enables at bits 11, 10, 9
// RULE7 - Frequency-locked-loop enables at bits 8 to 4
// RULE8 - Oscillator-ready enables at bits 3 to 0
// RULE9 - Clear register: writing one disables that enable
// RULE10 - Flag at 0x08 set on status rising edge
// RULE11 - Writing one clears flag, zero leaves it
// RULE12 - All enabled flagged sources ORed to one line
package sie_pkg;

  localparam int          SRC_W            = 12;
  localparam int          DATA_W           = 32;
  localparam int          ADDR_W           = 4;

  // Byte addresses of the registers
  localparam logic [3:0]  OFS_ENABLE_CLEAR = 4'h0;
  localparam logic [3:0]  OFS_ENABLE_SET   = 4'h4; // RULE1
  localparam logic [3:0]  OFS_FLAG         = 4'h8; // RULE10
  localparam logic [3:0]  OFS_STATUS       = 4'hC;

  localparam logic [11:0] ENABLE_RESET     = 12'h000; // RULE1
  localparam logic [11:0] FLAG_RESET       = 12'h000;
  localparam logic [19:0] RESERVED_READ    = 20'h00000;

  // Source bit map shared by enable, flag and status registers
  typedef struct packed {
    logic supply_mon_sync_ready;  // RULE6
    logic supply_mon_detect;
    logic supply_mon_ready;
    logic fll_ref_clock_stopped;  // RULE7
    logic fll_coarse_lock;
    logic fll_fine_lock;
    logic fll_out_of_bounds;
    logic fll_ready;
    logic int_8mhz_osc_ready;     // RULE8
    logic int_32khz_osc_ready;
    logic crystal_32khz_ready;
    logic main_crystal_ready;
  } sie_src_type;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [3:0]        byteenable;
  } sie_avs_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
  } sie_avs_rsp_type;

endpackage

// File: rtl/sie_rise_detect.sv
// Synchroniser and rising-edge detector for the status inputs
`timescale 1ns/1ps
module sie_rise_detect
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [11:0]     statusPin,
  output sie_pkg::sie_src_type statusSync,
  output sie_pkg::sie_src_type statusRise
);
  import sie_pkg::*;

  logic [11:0] syncFirst;
  logic [11:0] statusPrev;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syncFirst  <= 12'h000;
      statusSync <= 12'h000;
    end
    else
    begin
      syncFirst  <= statusPin;
      statusSync <= syncFirst;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Previous value for edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
      statusPrev <= 12'h000;
    else
      statusPrev <= statusSync;
  end

  assign statusRise = statusSync & ~statusPrev; // RULE10

endmodule

// File: tb/testbench.sv
// Self-checking testbench for the interrupt enable block
`timescale 1ns/1ps
module testbench;
  import sie_pkg::*;
  logic            clk;
  logic            rst;
  sie_avs_req_type avs;
  sie_avs_rsp_type avsRsp;
  logic            writeProtect;
  logic [11:0]     statusPin;
  logic            irq;
  int              bad_count;
  int              n_tests;

  sie_irq_ctrl DUT
  (
    .clk          (clk),
    .rst          (rst),
    .avs          (avs),
    .avsRsp       (avsRsp),
    .writeProtect (writeProtect),
    .statusPin    (statusPin),
    .irq          (irq)
  );

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs.address   <= a;
    avs.read      <= !w;
    avs.write     <= w;
    avs.writedata <= d;
    avs.byteenable <= 4'hF;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avsRsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk("bus answer", 32'h1, 32'h0);
    q = avsRsp.readdata;
    avs.read  <= 1'b0;
    avs.write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input string name);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(name, q, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(OFS_ENABLE_SET, 32'h00000000, "enable after reset");
    chk("irq after reset", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_set_clear;
    wr(OFS_ENABLE_SET, 32'h00000A5A);
    rdchk(OFS_ENABLE_SET, 32'h00000A5A, "set ones");
    wr(OFS_ENABLE_SET, 32'h000005A0);
    rdchk(OFS_ENABLE_SET, 32'h00000FFA, "zeros kept");
    wr(OFS_ENABLE_CLEAR, 32'h0000000F);
    rdchk(OFS_ENABLE_CLEAR, 32'h00000FF0, "clear ones");
    writeProtect <= 1'b1;
    wr(OFS_ENABLE_SET, 32'h00000FFF);
    wr(OFS_ENABLE_CLEAR, 32'h00000FF0);
    rdchk(OFS_ENABLE_SET, 32'h00000FF0, "protected");
    writeProtect <= 1'b0;
    wr(OFS_ENABLE_CLEAR, 32'hFFFFFFFF);
    rdchk(OFS_ENABLE_SET, 32'h00000000, "clear all");
    rdchk(4'h2, 32'h00000000, "unmapped read");
  endtask

  // Each source in turn: flag, masking, request and flag clearing
  task automatic t_bits;
    logic [31:0] m;
    for (int i = 0; i < 12; i++)
    begin
      m = 32'h00000001 << i;
      wr(OFS_ENABLE_CLEAR, 32'h00000FFF);
      statusPin <= m[11:0];
      repeat (5) @(posedge clk);
      rdchk(OFS_FLAG, m, "flag set");
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(OFS_ENABLE_SET, m);
      rdchk(OFS_ENABLE_SET, m, "bit place");
      chk("irq enabled", {31'h0, irq}, 32'h1);
      wr(OFS_FLAG, ~m & 32'h00000FFF);
      rdchk(OFS_FLAG, m, "flag kept");
      wr(OFS_FLAG, m);
      repeat (2) @(posedge clk);
      chk("irq after clear", {31'h0, irq}, 32'h0);
      statusPin <= 12'h000;
    end
  endtask

  // Named fields against bit positions, then a reset in mid-run
  task automatic t_map_reset;
    sie_src_type s;
    s = '0;
    s.supply_mon_sync_ready = 1'b1;
    s.fll_ref_clock_stopped = 1'b1;
    s.fll_ready             = 1'b1;
    s.int_8mhz_osc_ready    = 1'b1;
    s.main_crystal_ready    = 1'b1;
    repeat (4) @(posedge clk);
    statusPin <= s;
    wr(OFS_ENABLE_SET, 32'h00000FFF);
    repeat (3) @(posedge clk);
    rdchk(OFS_STATUS, 32'h00000919, "status map");
    rdchk(OFS_FLAG, 32'h00000919, "flag map");
    chk("irq map", {31'h0, irq}, 32'h1);
    rst       <= 1'b1;
    statusPin <= 12'h000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFS_ENABLE_SET, 32'h00000000, "enable mid reset");
    rdchk(OFS_FLAG, 32'h00000000, "flag mid reset");
    chk("irq mid reset", {31'h0, irq}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk          = 1'b0;
    rst          = 1'b1;
    avs          = '0;
    writeProtect = 1'b0;
    statusPin    = 12'h000;
    bad_count    = 0;
    n_tests      = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_set_clear();
    t_bits();
    t_map_reset();
    final_report();
  end

  initial
  begin
    #20000;
    bad_count++;
    final_report();
  end
endmodule
